// [bbx_pkg.sv]
package bbx_pkg;

	// ==========================================================
	// Register map (byte addresses on the APB)
	localparam logic [15:0] REG_CTRL   = 16'h0000;
	localparam logic [15:0] REG_INSTR  = 16'h0004;
	localparam logic [15:0] REG_ACC    = 16'h0008;
	localparam logic [15:0] REG_PSW    = 16'h000C;
	localparam logic [15:0] REG_PC     = 16'h0010;
	localparam logic [15:0] REG_STATUS = 16'h0014;
	localparam logic [15:0] MEM_BASE   = 16'h1000;

	// ==========================================================
	// Field positions
	localparam int CTRL_GO       = 0;
	localparam int STAT_BUSY     = 4;
	localparam int STAT_BAD      = 5;
	localparam int PSW_N         = 7;
	localparam int PSW_V         = 6;
	localparam int PSW_G         = 5;
	localparam int PSW_Z         = 1;
	localparam int PSW_C         = 0;

	// ==========================================================
	// Values after reset
	localparam logic [7:0]  RST_ACC = 8'h00;
	localparam logic [7:0]  RST_PSW = 8'h00;
	localparam logic [15:0] RST_PC  = 16'h0000;

	// ==========================================================
	// Opcodes
	localparam logic [7:0] OPC_CARRY_AND  = 8'h8B;
	localparam logic [7:0] OPC_CARRY_XOR  = 8'hAB;
	localparam logic [7:0] OPC_CARRY_LOAD = 8'hCB;
	localparam logic [7:0] OPC_CARRY_OR   = 8'h6B;
	localparam logic [7:0] OPC_BIT_INVERT = 8'h4B;
	localparam logic [7:0] OPC_CARRY_STORE= 8'hEB;
	localparam logic [7:0] OPC_TEST_DP    = 8'h0C;
	localparam logic [7:0] OPC_TEST_ABS   = 8'h1C;
	localparam logic [7:0] OPC_TEST_CLEAR = 8'h5C;
	localparam logic [7:0] OPC_TEST_SET   = 8'h3C;
	localparam logic [7:0] OPC_ACC_CLEAR  = 8'h2B;
	localparam logic [7:0] OPC_ACC_SET    = 8'h0B;
	localparam logic [7:0] OPC_CARRY_CLR  = 8'h20;
	localparam logic [7:0] OPC_CARRY_SET  = 8'hA0;
	localparam logic [7:0] OPC_GFLAG_CLR  = 8'h40;
	localparam logic [7:0] OPC_GFLAG_SET  = 8'hC0;
	localparam logic [7:0] OPC_OVF_CLR    = 8'h80;
	localparam logic [7:0] OPC_BR_C0      = 8'h50;
	localparam logic [7:0] OPC_BR_C1      = 8'hD0;
	localparam logic [7:0] OPC_BR_Z1      = 8'hF0;
	localparam logic [7:0] OPC_BR_Z0      = 8'h70;
	localparam logic [7:0] OPC_BR_N1      = 8'h90;
	localparam logic [7:0] OPC_BR_N0      = 8'h10;
	localparam logic [7:0] OPC_BR_ALWAYS  = 8'h2F;
	localparam logic [3:0] FAM_MEM_BIT    = 4'h1;
	localparam logic [3:0] FAM_BR_ACC     = 4'h2;
	localparam logic [3:0] FAM_BR_DP      = 4'h3;

	// ==========================================================
	// Cycle counts (not-taken count for branches)
	localparam logic [3:0] CYC_CARRY_AND  = 4'h4;
	localparam logic [3:0] CYC_CARRY_XOR  = 4'h5;
	localparam logic [3:0] CYC_CARRY_LOAD = 4'h4;
	localparam logic [3:0] CYC_CARRY_OR   = 4'h5;
	localparam logic [3:0] CYC_BIT_INVERT = 4'h5;
	localparam logic [3:0] CYC_CARRY_STORE= 4'h6;
	localparam logic [3:0] CYC_TEST_DP    = 4'h4;
	localparam logic [3:0] CYC_TEST_ABS   = 4'h5;
	localparam logic [3:0] CYC_TEST_RMW   = 4'h6;
	localparam logic [3:0] CYC_MEM_BIT    = 4'h4;
	localparam logic [3:0] CYC_SHORT      = 4'h2;
	localparam logic [3:0] CYC_BR_ACC     = 4'h4;
	localparam logic [3:0] CYC_BR_DP      = 4'h5;
	localparam logic [3:0] CYC_BR_ALWAYS  = 4'h4;
	localparam logic [3:0] CYC_TAKEN_ADD  = 4'h2;
	localparam logic [1:0] BYT_ONE        = 2'h1;
	localparam logic [1:0] BYT_TWO        = 2'h2;
	localparam logic [1:0] BYT_THREE      = 2'h3;

	// ==========================================================
	// Types
	typedef enum logic [4:0] {
		K_NONE, K_AND, K_XOR, K_LOAD, K_OR, K_INVERT, K_STORE, K_TEST,
		K_MSET, K_MCLR, K_ASET, K_ACLR, K_FLAG, K_TCLR, K_TSET,
		K_BFLAG, K_BBIT, K_BUNCOND
	} bbx_kind_type;

	typedef enum logic [1:0] {
		PH_IDLE, PH_READ, PH_EVAL, PH_WAIT
	} bbx_phase_type;

	typedef struct packed {
		bbx_kind_type kind;
		logic [1:0]   nbytes;
		logic [3:0]   cyc;
		logic         mem;
		logic [15:0]  addr;
		logic [2:0]   bitn;
		logic         neg;
		logic [7:0]   rel;
	} bbx_dec_type;

endpackage

// [bbx_dmem.sv]
// Data memory with registered read data; contents survive reset
module bbx_dmem
	import bbx_pkg::*;
#(
	parameter int AW = 9
) (
	input  wire logic          clock,
	input  wire logic          rstn,
	input  wire logic          we,
	input  wire logic [AW-1:0] addr,
	input  wire logic [7:0]    wdata,
	output logic      [7:0]    rdata
);

	typedef struct packed {
		logic [(1<<AW)-1:0][7:0] cells;
		logic [7:0]              rdata;
	} bbx_mem_state_type;

	bbx_mem_state_type mem_reg;
	bbx_mem_state_type mem_next;

	// ==========================================================
	// Next state: write port and read register
	always_comb begin
		mem_next = mem_reg;
		mem_next.rdata = mem_reg.cells[addr];
		if (we) begin
			mem_next.cells[addr] = wdata;
		end
		if (!rstn) begin
			mem_next.rdata = 8'h00;
		end
	end

	always_ff @(posedge clock) begin
		mem_reg <= mem_next;
	end

	assign rdata = mem_reg.rdata;

endmodule

// [bbx_exec.sv]
// Contract
// - 8B: carry AND memory bit or its complement; 3 bytes, 4 cycles
// - Bit test: Z from A AND M, N from M7, V from M6; 0C/1C
// - Families x1/y1 set or clear a direct-page bit; 2 bytes, 4 cycles
// - 2B clears, 0B sets an accumulator bit; 2 bytes, 2 cycles
// - 20 clears carry, A0 sets carry; 2 cycles
// - 40 clears G, C0 sets G; 2 cycles
// - 80 clears overflow in 2 cycles
// - AB: carry XOR memory bit or its complement; 3 bytes, 5 cycles
// - CB: carry loads memory bit or its complement; 3 bytes, 4 cycles
// - 4B inverts the addressed memory bit; 3 bytes, 5 cycles
// - 6B: carry OR memory bit or its complement; 3 bytes, 5 cycles
// - EB writes carry into the addressed memory bit; 3 bytes, 6 cycles
// - 5C: N,Z from A minus M, then clear A's bits in memory
// - 3C: N,Z from A minus M, then set A's bits in memory
// - Branch when bit clear: y2 accumulator 4/6, y3 direct page 5/7
// - Branch when bit set: x2 accumulator 4/6, x3 direct page 5/7
// - 50 branches on carry 0, D0 on carry 1; 2/4 cycles
// - F0 branches on zero 1, 70 on zero 0; 2/4 cycles
// - 90 branches on negative 1, 10 on negative 0; 2/4 cycles
// - 2F always branches; 2 bytes, 4 cycles
module bbx_exec
	import bbx_pkg::*;
#(
	parameter int DM_AW = 9,
	parameter int PA_W  = 16
) (
	input  wire logic            clock,
	input  wire logic            rstn,
	input  wire logic            psel,
	input  wire logic            penable,
	input  wire logic            pwrite,
	input  wire logic [PA_W-1:0] paddr,
	input  wire logic [31:0]     pwdata,
	output logic      [31:0]     prdata,
	output logic                 pready,
	output logic                 pslverr
);

	typedef struct packed {
		bbx_phase_type    phase;
		logic [3:0]       cnt;
		logic [7:0]       opc;
		logic [7:0]       op1;
		logic [7:0]       op2;
		logic [7:0]       acc;
		logic [7:0]       psw;
		logic [15:0]      pc;
		bbx_kind_type     kind;
		logic [1:0]       nbytes;
		logic [DM_AW-1:0] maddr;
		logic [2:0]       mbit;
		logic             neg;
		logic [7:0]       rel;
		logic             bad_op;
		logic [3:0]       run_cnt;
		logic             apb_pend;
		logic [31:0]      prdata;
		logic             pready;
		logic             pslverr;
	} bbx_state_type;

	bbx_state_type    st_reg;
	bbx_state_type    st_next;
	logic             mem_we;
	logic [DM_AW-1:0] mem_addr;
	logic [7:0]       mem_wdata;
	logic [7:0]       mem_rdata;

	// ==========================================================
	// Decoder: kind, length, cycle count and operand address
	function automatic bbx_dec_type decode(input logic [7:0] opc, input logic [7:0] op1,
		input logic [7:0] op2, input logic gsel);
		bbx_dec_type d;
		d        = '0;
		d.kind   = K_NONE;
		d.nbytes = BYT_TWO;
		d.addr   = {7'h00, gsel, op1};
		d.bitn   = opc[7:5];
		d.rel    = op1;
		case (opc)
			OPC_CARRY_AND:   begin d.kind = K_AND;    d.cyc = CYC_CARRY_AND;   end
			OPC_CARRY_XOR:   begin d.kind = K_XOR;    d.cyc = CYC_CARRY_XOR;   end
			OPC_CARRY_LOAD:  begin d.kind = K_LOAD;   d.cyc = CYC_CARRY_LOAD;  end
			OPC_CARRY_OR:    begin d.kind = K_OR;     d.cyc = CYC_CARRY_OR;    end
			OPC_BIT_INVERT:  begin d.kind = K_INVERT; d.cyc = CYC_BIT_INVERT;  end
			OPC_CARRY_STORE: begin d.kind = K_STORE;  d.cyc = CYC_CARRY_STORE; end
			OPC_TEST_DP: begin
				d.kind = K_TEST;
				d.cyc  = CYC_TEST_DP;
				d.mem  = 1'b1;
			end
			OPC_TEST_ABS, OPC_TEST_CLEAR, OPC_TEST_SET: begin
				d.kind   = (opc == OPC_TEST_ABS) ? K_TEST : ((opc == OPC_TEST_CLEAR) ? K_TCLR : K_TSET);
				d.cyc    = (opc == OPC_TEST_ABS) ? CYC_TEST_ABS : CYC_TEST_RMW;
				d.nbytes = BYT_THREE;
				d.mem    = 1'b1;
				d.addr   = {op2, op1};
			end
			OPC_ACC_CLEAR, OPC_ACC_SET: begin
				d.kind = (opc == OPC_ACC_CLEAR) ? K_ACLR : K_ASET;
				d.cyc  = CYC_SHORT;
				d.bitn = op1[2:0];
			end
			OPC_CARRY_CLR, OPC_CARRY_SET, OPC_GFLAG_CLR, OPC_GFLAG_SET, OPC_OVF_CLR: begin
				d.kind   = K_FLAG;
				d.cyc    = CYC_SHORT;
				d.nbytes = BYT_ONE;
			end
			OPC_BR_C0, OPC_BR_C1, OPC_BR_Z1, OPC_BR_Z0, OPC_BR_N1, OPC_BR_N0: begin
				d.kind = K_BFLAG;
				d.cyc  = CYC_SHORT;
			end
			OPC_BR_ALWAYS: begin
				d.kind = K_BUNCOND;
				d.cyc  = CYC_BR_ALWAYS;
			end
			default: begin
				case (opc[3:0])
					FAM_MEM_BIT: begin
						d.kind = opc[4] ? K_MCLR : K_MSET;
						d.cyc  = CYC_MEM_BIT;
						d.mem  = 1'b1;
					end
					FAM_BR_ACC: begin
						d.kind = K_BBIT;
						d.cyc  = CYC_BR_ACC;
					end
					FAM_BR_DP: begin
						d.kind   = K_BBIT;
						d.cyc    = CYC_BR_DP;
						d.nbytes = BYT_THREE;
						d.mem    = 1'b1;
						d.rel    = op2;
					end
					default: begin
						d.kind = K_NONE;
					end
				endcase
			end
		endcase
		// Absolute bit operand: 12-bit address, negate flag, bit number on top
		case (d.kind)
			K_AND, K_XOR, K_LOAD, K_OR, K_INVERT, K_STORE: begin
				d.nbytes = BYT_THREE;
				d.mem    = 1'b1;
				d.addr   = {4'h0, op2[3:0], op1};
				d.bitn   = op2[7:5];
				d.neg    = op2[4];
			end
			default: begin
				d.neg = 1'b0;
			end
		endcase
		return d;
	endfunction

	// ==========================================================
	// Next state: APB slave, sequencing and execution
	always_comb begin
		bbx_dec_type      dec;
		logic             access;
		logic             mem_hit;
		logic [PA_W-1:0]  base;
		logic [15:0]      reg_addr;
		logic [7:0]       mask;
		logic [7:0]       diff;
		logic             opd;
		logic             taken;
		logic [15:0]      seq_pc;
		dec       = decode(st_reg.opc, st_reg.op1, st_reg.op2, st_reg.psw[PSW_G]);
		st_next   = st_reg;
		mem_we    = 1'b0;
		mem_addr  = st_reg.maddr;
		mem_wdata = 8'h00;
		access    = psel && penable && !st_reg.pready;
		base      = PA_W'(MEM_BASE);
		mem_hit   = (paddr >> (DM_AW + 2)) == (base >> (DM_AW + 2));
		reg_addr  = 16'(paddr);
		mask      = 8'h01 << st_reg.mbit;
		diff      = st_reg.acc - mem_rdata;
		opd       = mem_rdata[st_reg.mbit] ^ st_reg.neg;
		taken     = 1'b0;
		seq_pc    = st_reg.pc + {14'h0000, st_reg.nbytes};
		st_next.pready  = 1'b0;
		st_next.pslverr = 1'b0;

		// Sequencer: the counter sets the whole instruction length
		if (st_reg.phase != PH_IDLE) begin
			st_next.run_cnt = st_reg.run_cnt + 4'h1;
			st_next.cnt     = st_reg.cnt - 4'h1;
			st_next.phase   = (st_reg.phase == PH_READ) ? PH_EVAL : PH_WAIT;
			if (st_reg.cnt == 4'h0) begin
				st_next.phase = PH_IDLE;
			end
		end

		// Evaluation: memory data is valid in this cycle
		if (st_reg.phase == PH_EVAL) begin
			case (st_reg.kind)
				K_AND:  st_next.psw[PSW_C] = st_reg.psw[PSW_C] & opd;
				K_XOR:  st_next.psw[PSW_C] = st_reg.psw[PSW_C] ^ opd;
				K_LOAD: st_next.psw[PSW_C] = opd;
				K_OR:   st_next.psw[PSW_C] = st_reg.psw[PSW_C] | opd;
				K_INVERT: begin
					mem_we    = 1'b1;
					mem_wdata = mem_rdata ^ mask;
				end
				K_STORE: begin
					mem_we    = 1'b1;
					mem_wdata = st_reg.psw[PSW_C] ? (mem_rdata | mask) : (mem_rdata & ~mask);
				end
				K_TEST: begin
					st_next.psw[PSW_Z] = (st_reg.acc & mem_rdata) == 8'h00;
					st_next.psw[PSW_N] = mem_rdata[7];
					st_next.psw[PSW_V] = mem_rdata[6];
				end
				K_TCLR, K_TSET: begin
					st_next.psw[PSW_N] = diff[7];
					st_next.psw[PSW_Z] = diff == 8'h00;
					mem_we    = 1'b1;
					mem_wdata = (st_reg.kind == K_TCLR) ? (mem_rdata & ~st_reg.acc) : (mem_rdata | st_reg.acc);
				end
				K_MSET, K_MCLR: begin
					mem_we    = 1'b1;
					mem_wdata = (st_reg.kind == K_MSET) ? (mem_rdata | mask) : (mem_rdata & ~mask);
				end
				K_ASET: st_next.acc = st_reg.acc | mask;
				K_ACLR: st_next.acc = st_reg.acc & ~mask;
				K_FLAG: begin
					case (st_reg.opc)
						OPC_CARRY_CLR: st_next.psw[PSW_C] = 1'b0;
						OPC_CARRY_SET: st_next.psw[PSW_C] = 1'b1;
						OPC_GFLAG_CLR: st_next.psw[PSW_G] = 1'b0;
						OPC_GFLAG_SET: st_next.psw[PSW_G] = 1'b1;
						default:       st_next.psw[PSW_V] = 1'b0;
					endcase
				end
				K_BFLAG: begin
					case (st_reg.opc)
						OPC_BR_C0: taken = !st_reg.psw[PSW_C];
						OPC_BR_C1: taken = st_reg.psw[PSW_C];
						OPC_BR_Z1: taken = st_reg.psw[PSW_Z];
						OPC_BR_Z0: taken = !st_reg.psw[PSW_Z];
						OPC_BR_N1: taken = st_reg.psw[PSW_N];
						default:   taken = !st_reg.psw[PSW_N];
					endcase
				end
				K_BBIT: begin
					// Accumulator form reads A; direct-page form reads memory
					if (st_reg.nbytes == BYT_TWO) begin
						taken = st_reg.acc[st_reg.mbit] != st_reg.opc[4];
					end else begin
						taken = mem_rdata[st_reg.mbit] != st_reg.opc[4];
					end
				end
				K_BUNCOND: taken = 1'b1;
				default: taken = 1'b0;
			endcase
			st_next.pc = seq_pc;
			if (taken) begin
				st_next.pc  = seq_pc + {{8{st_reg.rel[7]}}, st_reg.rel};
				st_next.cnt = st_reg.cnt - 4'h1 + ((st_reg.kind == K_BUNCOND) ? 4'h0 : CYC_TAKEN_ADD);
			end
		end

		// APB slave: one wait state for registers, two for memory reads while no instruction runs
		if (access) begin
			if (mem_hit) begin
				if (st_reg.phase == PH_IDLE) begin
					mem_addr = paddr[DM_AW+1:2];
					if (pwrite) begin
						mem_we         = 1'b1;
						mem_wdata      = pwdata[7:0];
						st_next.pready = 1'b1;
					end else if (!st_reg.apb_pend) begin
						st_next.apb_pend = 1'b1;
					end else begin
						st_next.apb_pend = 1'b0;
						st_next.prdata   = {24'h000000, mem_rdata};
						st_next.pready   = 1'b1;
					end
				end
			end else begin
				st_next.pready = 1'b1;
				st_next.prdata = 32'h00000000;
				if (!pwrite) begin
					case (reg_addr)
						REG_CTRL:   st_next.prdata = 32'h00000000;
						REG_INSTR:  st_next.prdata = {8'h00, st_reg.op2, st_reg.op1, st_reg.opc};
						REG_ACC:    st_next.prdata = {24'h000000, st_reg.acc};
						REG_PSW:    st_next.prdata = {24'h000000, st_reg.psw};
						REG_PC:     st_next.prdata = {16'h0000, st_reg.pc};
						REG_STATUS: st_next.prdata = {26'h0000000, st_reg.bad_op,
							st_reg.phase != PH_IDLE, st_reg.run_cnt};
						default:    st_next.pslverr = 1'b1;
					endcase
				end else if (st_reg.phase != PH_IDLE) begin
					// Operands must not move under a running instruction
					st_next.pslverr = 1'b1;
				end else begin
					case (reg_addr)
						REG_CTRL: begin
							if (pwdata[CTRL_GO]) begin
								st_next.bad_op = dec.kind == K_NONE;
								if (dec.kind != K_NONE) begin
									st_next.phase   = dec.mem ? PH_READ : PH_EVAL;
									st_next.cnt     = dec.cyc - 4'h1;
									st_next.run_cnt = 4'h0;
									st_next.kind    = dec.kind;
									st_next.nbytes  = dec.nbytes;
									st_next.maddr   = dec.addr[DM_AW-1:0];
									st_next.mbit    = dec.bitn;
									st_next.neg     = dec.neg;
									st_next.rel     = dec.rel;
								end
							end
						end
						REG_INSTR: begin
							st_next.opc = pwdata[7:0];
							st_next.op1 = pwdata[15:8];
							st_next.op2 = pwdata[23:16];
						end
						REG_ACC:    st_next.acc = pwdata[7:0];
						REG_PSW:    st_next.psw = pwdata[7:0];
						REG_PC:     st_next.pc  = pwdata[15:0];
						REG_STATUS: st_next.pslverr = 1'b0;
						default:    st_next.pslverr = 1'b1;
					endcase
				end
			end
		end

		// Synchronous reset
		if (!rstn) begin
			st_next          = '0;
			st_next.phase    = PH_IDLE;
			st_next.kind     = K_NONE;
			st_next.acc      = RST_ACC;
			st_next.psw      = RST_PSW;
			st_next.pc       = RST_PC;
			mem_we           = 1'b0;
		end
	end

	always_ff @(posedge clock) begin
		st_reg <= st_next;
	end

	// ==========================================================
	// Data memory and outputs
	bbx_dmem #(
		.AW (DM_AW)
	) u_dmem (
		.clock (clock),
		.rstn  (rstn),
		.we    (mem_we),
		.addr  (mem_addr),
		.wdata (mem_wdata),
		.rdata (mem_rdata)
	);

	assign prdata  = st_reg.prdata;
	assign pready  = st_reg.pready;
	assign pslverr = st_reg.pslverr;

endmodule

// [bbx_exec_asserts.sv]
module bbx_exec_asserts
	import bbx_pkg::*;
#(
	parameter int DM_AW = 9,
	parameter int PA_W  = 16
) (
	input wire logic            clock,
	input wire logic            rstn,
	input wire logic            psel,
	input wire logic            penable,
	input wire logic            pwrite,
	input wire logic [PA_W-1:0] paddr,
	input wire logic [31:0]     pwdata,
	input wire logic [31:0]     prdata,
	input wire logic            pready,
	input wire logic            pslverr
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking cb @(posedge clock);
	endclocking
	default disable iff (!rstn);

	// ==========================================================
	// Bus phases
	sequence s_setup;
		psel && !penable;
	endsequence
	sequence s_read(logic [15:0] a);
		pready && !pwrite && paddr == a;
	endsequence

	// ==========================================================
	// Handshake, one wait state on the register file
	property p_reg_wait;
		s_setup ##1 (psel && penable && paddr < 16'h0018) |=> pready;
	endproperty
	property p_pulse;
		pready |=> !pready;
	endproperty
	property p_in_access;
		pready |-> psel && penable;
	endproperty
	property p_err_with_ready;
		pslverr |-> pready;
	endproperty
	// Holes below the memory window answer with an error and no data
	property p_unmapped;
		pready && paddr >= 16'h0018 && paddr < MEM_BASE |-> pslverr && prdata == 32'h0;
	endproperty
	property p_ctrl_zero;
		s_read(REG_CTRL) |-> prdata == 32'h0;
	endproperty
	// A finished run can only report one of the documented counts
	property p_cycle_count;
		s_read(REG_STATUS) ##0 (!prdata[STAT_BUSY] && prdata[3:0] != 4'h0)
			|-> prdata[3:0] inside {4'h2, 4'h4, 4'h5, 4'h6, 4'h7};
	endproperty
	property p_pc_width;
		s_read(REG_PC) |-> prdata[31:16] == 16'h0;
	endproperty

	a_reg_wait: assert property (p_reg_wait) else $error("register access not answered after one wait");
	a_pulse: assert property (p_pulse) else $error("ready longer than one cycle");
	a_in_access: assert property (p_in_access) else $error("ready outside an access");
	a_err_with_ready: assert property (p_err_with_ready) else $error("error without ready");
	a_unmapped: assert property (p_unmapped) else $error("unmapped access not refused");
	a_ctrl_zero: assert property (p_ctrl_zero) else $error("control register read nonzero");
	a_cycle_count: assert property (p_cycle_count) else $error("impossible cycle count");
	a_pc_width: assert property (p_pc_width) else $error("program counter upper bits set");
endmodule

bind bbx_exec bbx_exec_asserts #(.DM_AW(DM_AW), .PA_W(PA_W)) u_chk (
	.clock(clock), .rstn(rstn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
	.pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));

// [bbx_host_model.sv]
// Bus master standing in for the host side of the register bus
module bbx_host_model
	import bbx_pkg::*;
(
	input  wire logic        clock,
	output logic             psel,
	output logic             penable,
	output logic             pwrite,
	output logic [15:0]      paddr,
	output logic [31:0]      pwdata,
	input  wire logic [31:0] prdata,
	input  wire logic        pready,
	input  wire logic        pslverr
);
	timeunit 1ns;
	timeprecision 1ps;

	// Idle bus from time zero
	initial begin
		psel    = 1'h0;
		penable = 1'h0;
		pwrite  = 1'h0;
		paddr   = 16'h0;
		pwdata  = 32'h0;
	end

	// One transfer; random idle gaps so the slave sees both paces
	task automatic xfer(input logic w, input logic [15:0] a, input logic [31:0] d,
		output logic [31:0] q, output logic e);
		@(posedge clock);
		repeat ($urandom % 2) @(posedge clock);
		psel    <= 1'h1;
		penable <= 1'h0;
		pwrite  <= w;
		paddr   <= a;
		pwdata  <= d;
		@(posedge clock);
		penable <= 1'h1;
		// No cycle budget here: only the bench watchdog ends a wait
		do begin
			@(posedge clock);
		end while (pready !== 1'h1);
		q = prdata;
		e = pslverr;
		psel    <= 1'h0;
		penable <= 1'h0;
		// Released lines show garbage, not the last value
		paddr   <= ~a;
		pwdata  <= ~d;
	endtask
endmodule

// [bit_and_branch_exec_bench.sv]
module bit_and_branch_exec_bench
	import bbx_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	logic             clock = 1'h0;
	logic             rstn = 1'h0;
	wire logic        psel;
	wire logic        penable;
	wire logic        pwrite;
	wire logic        pready;
	wire logic        pslverr;
	wire logic [15:0] paddr;
	wire logic [31:0] pwdata;
	wire logic [31:0] prdata;
	int               n_errors = 0;
	int               comparisons = 0;
	logic [7:0]       t_mbit [6] = '{8'h8B, 8'hAB, 8'hCB, 8'h6B, 8'h4B, 8'hEB};
	logic [7:0]       t_test [4] = '{8'h0C, 8'h1C, 8'h5C, 8'h3C};
	logic [7:0]       t_flag [7] = '{8'h20, 8'hA0, 8'h40, 8'hC0, 8'h80, 8'h0B, 8'h2B};
	logic [7:0]       t_br [7] = '{8'h50, 8'hD0, 8'hF0, 8'h70, 8'h90, 8'h10, 8'h2F};

	// ==========================================================
	// Clock, design and host
	always #2.5 clock = ~clock;

	bbx_exec u_dut (.clock(clock), .rstn(rstn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));
	bbx_host_model u_host (.clock(clock), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));

	// ==========================================================
	// Checking and bus helpers
	task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp) begin
			n_errors++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic wr(input logic [15:0] a, input logic [31:0] d);
		logic [31:0] q;
		logic        e;
		u_host.xfer(1'h1, a, d, q, e);
	endtask
	task automatic rd(input logic [15:0] a, output logic [31:0] q);
		logic e;
		u_host.xfer(1'h0, a, 32'h0, q, e);
	endtask
	task automatic test_done();
		$display("comparisons %0d mismatches %0d", comparisons, n_errors);
		if (n_errors == 0 && comparisons > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask

	// ==========================================================
	// Reference model: length in the upper bits, base cycles below
	function automatic logic [5:0] shape(input logic [7:0] op);
		case (op)
			8'h8B, 8'hCB: return 6'h34;
			8'hAB, 8'h6B, 8'h4B, 8'h1C: return 6'h35;
			8'hEB, 8'h5C, 8'h3C: return 6'h36;
			8'h0C: return 6'h24;
			8'h0B, 8'h2B, 8'h50, 8'hD0, 8'hF0, 8'h70, 8'h90, 8'h10, 8'h2F: return 6'h22;
			default: return (op[3:0] == 4'h3) ? 6'h35 : (op[3:0] == 4'h0) ? 6'h12 : 6'h24;
		endcase
	endfunction
	// Byte address of the operand in the memory window
	function automatic logic [15:0] mem_addr(input logic [7:0] op, o1, o2, p);
		logic hi;
		hi = (op[3:0] == 4'hB || op inside {8'h1C, 8'h5C, 8'h3C}) ? o2[0] : p[5];
		return MEM_BASE + {5'h00, hi, o1, 2'h0};
	endfunction
	function automatic void predict(input logic [7:0] op, o1, o2, a, p, m, input logic [15:0] pc,
		output logic [7:0] ea, ep, em, output logic [15:0] epc, output logic [3:0] ec);
		logic       b;
		logic       tk;
		logic [1:0] len;
		logic [7:0] d;
		logic [7:0] off;
		b   = m[o2[7:5]] ^ o2[4];
		d   = a - m;
		ea  = a;
		ep  = p;
		em  = m;
		tk  = 1'h0;
		off = o1;
		case (op)
			8'h8B: ep[0] = p[0] & b;
			8'hAB: ep[0] = p[0] ^ b;
			8'hCB: ep[0] = b;
			8'h6B: ep[0] = p[0] | b;
			8'h4B: em[o2[7:5]] = ~m[o2[7:5]];
			8'hEB: em[o2[7:5]] = p[0];
			8'h0C, 8'h1C: ep = {m[7:6], p[5:2], (a & m) == 8'h00, p[0]};
			8'h5C: em = m & ~a;
			8'h3C: em = m | a;
			8'h0B, 8'h2B: ea[o1[2:0]] = ~op[5];
			8'h20, 8'hA0: ep[0] = op[7];
			8'h40, 8'hC0: ep[5] = op[7];
			8'h80: ep[6] = 1'h0;
			8'h50, 8'hD0: tk = p[0] == op[7];
			8'hF0, 8'h70: tk = p[1] == op[7];
			8'h90, 8'h10: tk = p[7] == op[7];
			8'h2F: tk = 1'h1;
			default: begin
				if (op[3:0] == 4'h1)
					em[op[7:5]] = ~op[4];
				tk  = (op[3:0] == 4'h2) ? a[op[7:5]] != op[4] : (op[3:0] == 4'h3) && m[op[7:5]] != op[4];
				off = (op[3:0] == 4'h3) ? o2 : o1;
			end
		endcase
		if (op inside {8'h5C, 8'h3C})
			ep = {d[7], p[6:2], d == 8'h00, p[0]};
		{len, ec} = shape(op);
		ec  = ec + (tk ? 4'h2 : 4'h0);
		epc = pc + 16'(len) + (tk ? {{8{off[7]}}, off} : 16'h0000);
	endfunction

	// One instruction: load state, start, poll, compare everything
	task automatic run(input logic [7:0] op, o1, o2, a, m);
		logic [7:0]  p;
		logic [7:0]  ea;
		logic [7:0]  ep;
		logic [7:0]  em;
		logic [15:0] pc;
		logic [15:0] epc;
		logic [3:0]  ec;
		logic [31:0] q;
		int          k;
		p  = 8'($urandom);
		pc = 16'($urandom);
		predict(op, o1, o2, a, p, m, pc, ea, ep, em, epc, ec);
		wr(mem_addr(op, o1, o2, p), {24'h0, m});
		wr(REG_ACC, {24'h0, a});
		wr(REG_PSW, {24'h0, p});
		wr(REG_PC, {16'h0, pc});
		wr(REG_INSTR, {8'h00, o2, o1, op});
		wr(REG_CTRL, 32'h1);
		k = 0;
		do begin
			rd(REG_STATUS, q);
			k++;
		end while (q[STAT_BUSY] !== 1'h0 && k < 40);
		chk("busy after poll", {31'h0, q[STAT_BUSY]}, 32'h0);
		chk("cycle count", {28'h0, q[3:0]}, {28'h0, ec});
		rd(REG_ACC, q);
		chk("accumulator", q, {24'h0, ea});
		rd(REG_PSW, q);
		chk("status word", q, {24'h0, ep});
		rd(REG_PC, q);
		chk("program counter", q, {16'h0, epc});
		rd(mem_addr(op, o1, o2, p), q);
		chk("memory byte", q, {24'h0, em});
	endtask
	task automatic rand_runs(input logic [7:0] op, input int n);
		repeat (n) run(op, 8'($urandom), 8'($urandom), 8'($urandom), 8'($urandom));
	endtask

	// ==========================================================
	// Main sequence
	initial begin
		logic [31:0] q;
		logic        e;
		void'($urandom(64));
		repeat (10) @(posedge clock);
		rstn <= 1'h1;
		for (int i = 0; i < 6; i++) begin
			rd(16'(4 * i), q);
			chk("reset value", q, 32'h0);
		end
		$display("reset values done");
		foreach (t_mbit[j]) rand_runs(t_mbit[j], 8);
		$display("carry bit operations done");
		foreach (t_test[j]) rand_runs(t_test[j], 6);
		run(8'h5C, 8'h40, 8'h00, 8'h5A, 8'h5A);
		run(8'h3C, 8'h41, 8'h01, 8'h80, 8'h00);
		$display("bit test operations done");
		foreach (t_flag[j]) rand_runs(t_flag[j], 4);
		$display("flag operations done");
		foreach (t_br[j]) rand_runs(t_br[j], 8);
		run(8'h2F, 8'h80, 8'h00, 8'h00, 8'h00);
		run(8'h2F, 8'h7F, 8'h00, 8'h00, 8'h00);
		$display("flag branches done");
		for (int i = 0; i < 48; i++) rand_runs(8'(16 * (i % 16) + i / 16 + 1), 3);
		$display("bit families done");
		u_host.xfer(1'h0, 16'h0018, 32'h0, q, e);
		chk("unmapped error", {31'h0, e}, 32'h1);
		chk("unmapped data", q, 32'h0);
		wr(REG_INSTR, 32'h0000_00FF);
		wr(REG_CTRL, 32'h1);
		rd(REG_STATUS, q);
		chk("unknown opcode flag", {31'h0, q[STAT_BAD]}, 32'h1);
		rd(REG_CTRL, q);
		chk("control readback", q, 32'h0);
		$display("refusals done");
		test_done();
	end

	// Hang guard, well beyond the expected run length
	initial begin
		repeat (60000) @(posedge clock);
		n_errors++;
		$display("watchdog expired");
		test_done();
	end
endmodule
